// ### ugef_map.svh
// register offsets, field positions, reset values and timing for the event flags
`ifndef UGEF_MAP_SVH
`define UGEF_MAP_SVH
`define UGEF_FLAGS_OFS     8'hbd
`define UGEF_ENABLE_OFS    8'hbe
`define UGEF_FLAGS_RST     8'h00
`define UGEF_ENABLE_RST    8'h10
`define UGEF_VALID_MASK    8'h39
`define UGEF_BIT_SUSPEND   0
`define UGEF_BIT_FRAME     3
`define UGEF_BIT_RESET_END 4
`define UGEF_BIT_CPU_WAKE  5
`define UGEF_SUSPEND_US    3000
`define UGEF_CLK_MHZ       25
`endif

// ### ugef_pkg.sv
// types for the usb global event flag block
package ugef_pkg;
  typedef enum logic [1:0] {
    UGEF_ACTIVE    = 2'b01,
    UGEF_SUSPENDED = 2'b10
  } ugef_state_t;
  typedef struct packed {
    ugef_state_t state;
    logic [7:0]  flags;
    logic [7:0]  enable;
    logic [7:0]  rdata;
    logic [31:0] idle_cnt;
  } ugef_regs_t;
endpackage

// ### ugef_event_flags.sv
// usb global event flag and enable registers with interrupt request
`include "ugef_map.svh"
`timescale 1ns/100ps
`default_nettype none
module ugef_event_flags
  import ugef_pkg::*;
#(
  parameter int unsigned SUSPEND_CYCLES =
    `UGEF_SUSPEND_US * `UGEF_CLK_MHZ
) (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  // bus event inputs
  input  wire logic       bus_idle_j,
  input  wire logic       bus_non_idle,
  input  wire logic       upstream_resume,
  input  wire logic       bus_reset_end,
  input  wire logic       frame_start,
  // status and interrupt
  output logic            suspended,
  output logic            usb_irq
);

  // the suspend compare looks one count below the limit, so it needs two
  if (SUSPEND_CYCLES < 2) begin : g_bad_cycles
    $error("SUSPEND_CYCLES too small");
  end

  ugef_regs_t q, d;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic       wr_flags;
  logic       wr_enable;

  always_comb begin
    d = q;
    set_v = 8'h00;
    clr_v = 8'h00;
    wr_flags = 1'b0;
    wr_enable = 1'b0;
    if (wr_stb && addr == `UGEF_FLAGS_OFS) begin
      wr_flags = 1'b1;
    end else if (wr_stb && addr == `UGEF_ENABLE_OFS) begin
      wr_enable = 1'b1;
    end
    // idle timer counts only unbroken J state
    if (!bus_idle_j) begin
      d.idle_cnt = 32'h0;
    end else if (q.idle_cnt < SUSPEND_CYCLES) begin
      d.idle_cnt = q.idle_cnt + 32'h1;
    end
    case (q.state)
      UGEF_ACTIVE: begin
        if (bus_idle_j && q.idle_cnt == SUSPEND_CYCLES - 1) begin
          set_v[`UGEF_BIT_SUSPEND] = 1'b1;
          d.state = UGEF_SUSPENDED;
        end
      end
      UGEF_SUSPENDED: begin
        // resume we send ourselves must not wake the cpu
        if (bus_non_idle && !upstream_resume) begin
          set_v[`UGEF_BIT_CPU_WAKE] = 1'b1;
          d.state = UGEF_ACTIVE;
        end
      end
      default: d.state = UGEF_ACTIVE;
    endcase
    set_v[`UGEF_BIT_RESET_END] = bus_reset_end;
    set_v[`UGEF_BIT_FRAME] = frame_start;
    // write one to clear; a set in the same cycle wins
    if (wr_flags) begin
      clr_v = wdata & `UGEF_VALID_MASK;
    end
    d.flags = ((q.flags & ~clr_v) | set_v) & `UGEF_VALID_MASK;
    if (wr_enable) begin
      d.enable = wdata & `UGEF_VALID_MASK;
    end
    d.rdata = 8'h00;
    if (rd_stb && addr == `UGEF_FLAGS_OFS) begin
      d.rdata = q.flags;
    end else if (rd_stb && addr == `UGEF_ENABLE_OFS) begin
      d.rdata = q.enable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q.state <= UGEF_ACTIVE;
      q.flags <= `UGEF_FLAGS_RST;
      q.enable <= `UGEF_ENABLE_RST;
      q.rdata <= 8'h00;
      q.idle_cnt <= 32'h0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign suspended = (q.state == UGEF_SUSPENDED);
  assign usb_irq = |(q.flags & q.enable);

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (q.flags & ~`UGEF_VALID_MASK) == 8'h00)
    else $error("reserved flag bit set");


  wake_sets_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && q.state == UGEF_SUSPENDED && bus_non_idle && !upstream_resume
    |=> q.flags[`UGEF_BIT_CPU_WAKE])
    else $error("cpu wake flag not set");


  resume_nowake_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !q.flags[`UGEF_BIT_CPU_WAKE] && upstream_resume
    |=> !q.flags[`UGEF_BIT_CPU_WAKE])
    else $error("own resume set cpu wake");


  wake_irq_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.flags[`UGEF_BIT_CPU_WAKE] && q.enable[`UGEF_BIT_CPU_WAKE] |-> usb_irq)
    else $error("wake irq missing");


  suspend_time_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(q.flags[`UGEF_BIT_SUSPEND]) |-> q.idle_cnt == SUSPEND_CYCLES)
    else $error("suspend flag at wrong time");


  suspend_irq_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.flags[`UGEF_BIT_SUSPEND] && q.enable[`UGEF_BIT_SUSPEND] |-> usb_irq)
    else $error("suspend irq missing");


  sticky_flags_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !wr_flags && q.flags[`UGEF_BIT_FRAME]
    |=> q.flags[`UGEF_BIT_FRAME])
    else $error("frame flag lost");


  frame_sets_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && frame_start |=> q.flags[`UGEF_BIT_FRAME])
    else $error("frame flag not set");


  irq_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (q.flags & q.enable) == 8'h00 |-> !usb_irq)
    else $error("spurious irq");

  // flag setting and clearing
  reset_end_sets_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && bus_reset_end |=> q.flags[`UGEF_BIT_RESET_END])
    else $error("reset end flag not set");

  reset_end_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !wr_flags && q.flags[`UGEF_BIT_RESET_END]
    |=> q.flags[`UGEF_BIT_RESET_END])
    else $error("reset end flag lost");

  wake_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !wr_flags && q.flags[`UGEF_BIT_CPU_WAKE]
    |=> q.flags[`UGEF_BIT_CPU_WAKE])
    else $error("cpu wake flag lost");

  suspend_sticky_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !wr_flags && q.flags[`UGEF_BIT_SUSPEND]
    |=> q.flags[`UGEF_BIT_SUSPEND])
    else $error("suspend flag lost");

  flags_no_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !wr_flags
    |=> (q.flags & $past(q.flags)) == $past(q.flags))
    else $error("flag cleared without write");

  write_clears_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && wr_flags && wdata[`UGEF_BIT_FRAME] && !frame_start
    |=> !q.flags[`UGEF_BIT_FRAME])
    else $error("frame flag not cleared");

  frame_set_wins_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && wr_flags && wdata[`UGEF_BIT_FRAME] && frame_start
    |=> q.flags[`UGEF_BIT_FRAME])
    else $error("clear beat frame set");

  reset_set_wins_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && wr_flags && wdata[`UGEF_BIT_RESET_END] && bus_reset_end
    |=> q.flags[`UGEF_BIT_RESET_END])
    else $error("clear beat reset end set");

  // interrupt request
  reset_end_irq_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.flags[`UGEF_BIT_RESET_END] && q.enable[`UGEF_BIT_RESET_END]
    |-> usb_irq)
    else $error("reset end irq missing");

  frame_irq_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.flags[`UGEF_BIT_FRAME] && q.enable[`UGEF_BIT_FRAME] |-> usb_irq)
    else $error("frame irq missing");

  // enable register
  enable_write_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && wr_enable |=> q.enable == ($past(wdata) & `UGEF_VALID_MASK))
    else $error("enable write lost");

  enable_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !wr_enable |=> $stable(q.enable))
    else $error("enable changed unwritten");

  enable_reserved_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (q.enable & ~`UGEF_VALID_MASK) == 8'h00)
    else $error("reserved enable bit set");

  // register port reads
  rdata_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !rd_stb |=> rdata == 8'h00)
    else $error("read data without read");

  read_flags_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && rd_stb && addr == `UGEF_FLAGS_OFS
    |=> rdata == $past(q.flags))
    else $error("flag read wrong");

  read_enable_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && rd_stb && addr == `UGEF_ENABLE_OFS
    |=> rdata == $past(q.enable))
    else $error("enable read wrong");

  read_unmapped_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && rd_stb && addr != `UGEF_FLAGS_OFS
    && addr != `UGEF_ENABLE_OFS |=> rdata == 8'h00)
    else $error("unmapped read not zero");

  // clock enable low must freeze every register
  freeze_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(q))
    else $error("state moved while frozen");

  // suspend detection and wake
  suspend_enter_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && q.state == UGEF_ACTIVE && bus_idle_j
    && q.idle_cnt == SUSPEND_CYCLES - 1 |=> suspended)
    else $error("suspend not entered");

  suspend_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(q.flags[`UGEF_BIT_SUSPEND]) |-> $past(bus_idle_j))
    else $error("suspend without idle");

  suspend_state_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(q.flags[`UGEF_BIT_SUSPEND]) |-> suspended)
    else $error("suspend flag without state");

  idle_restart_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && !bus_idle_j |=> q.idle_cnt == 32'h0)
    else $error("idle count not restarted");

  idle_cap_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.idle_cnt <= SUSPEND_CYCLES)
    else $error("idle count past limit");

  wake_leaves_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && suspended && bus_non_idle && !upstream_resume
    |=> !suspended)
    else $error("wake left suspend unchanged");

  resume_stays_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_en && suspended && upstream_resume |=> suspended)
    else $error("own resume left suspend");

  wake_in_suspend_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(q.flags[`UGEF_BIT_CPU_WAKE])
    |-> $past(q.state == UGEF_SUSPENDED))
    else $error("wake flag outside suspend");

  state_onehot_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $onehot(q.state))
    else $error("state not one hot");

endmodule
`default_nettype wire

// ### ugef_host_model.sv
// host model driving the usb line conditions
`timescale 1ns/100ps
`default_nettype none
module ugef_host_model (
  // bench command: 0 j idle, 1 k, 2 reset end, 3 sof
  input  wire logic [1:0] op,
  // line conditions
  output logic            idle_j,
  output logic            non_idle,
  output logic            rst_end,
  output logic            sof
);
  assign idle_j   = (op == 2'h0);
  assign non_idle = (op == 2'h1);
  assign rst_end  = (op == 2'h2);
  assign sof      = (op == 2'h3);
endmodule
`default_nettype wire

// ### tb_usb_global_event_flags.sv
// self-checking bench for the usb event flags
`timescale 1ns/100ps
`default_nettype none
module tb_usb_global_event_flags;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0, res = 0;
  logic [7:0] a = 0, wd = 0, rdata;
  logic [1:0] op = 2'h1;
  logic       ce = 1;
  logic       idle_j, non_idle, rst_end, sof, susp, irq;
  int         n_fail = 0, check_count = 0;
  ugef_host_model host (.op(op), .idle_j(idle_j), .non_idle(non_idle),
    .rst_end(rst_end), .sof(sof));
  ugef_event_flags #(.SUSPEND_CYCLES(20)) uut (.clk(clk), .rst_n(rst_n),
    .clk_en(ce), .addr(a), .wdata(wd), .wr_stb(wr), .rd_stb(rd),
    .rdata(rdata), .bus_idle_j(idle_j), .bus_non_idle(non_idle),
    .upstream_resume(res), .bus_reset_end(rst_end), .frame_start(sof),
    .suspended(susp), .usb_irq(irq));
  initial forever #20 clk = ~clk;
  task chk(string n, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      n_fail++;
    end
  endtask
  task wrr(logic [7:0] ad, logic [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  // check at the falling edge so the registered read data has settled
  task rdc(string n, logic [7:0] ad, logic [7:0] e);
    @(posedge clk);
    a <= ad;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    @(negedge clk);
    chk(n, e, rdata);
  endtask
  task bus(logic [1:0] o, int n);
    @(posedge clk);
    op <= o;
    repeat (n - 1) @(posedge clk);
  endtask
  task t_reset;
    rdc("flags", 8'hbd, 8'h00);
    rdc("enable", 8'hbe, 8'h10);
    rdc("unmapped", 8'hbc, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    $display("reset test done");
  endtask
  task t_events;
    bus(2'h2, 1);
    bus(2'h3, 1);
    bus(2'h1, 1);
    rdc("flags", 8'hbd, 8'h18);
    chk("irq", 8'h01, {7'h0, irq});
    wrr(8'hbe, 8'hff);
    rdc("enable", 8'hbe, 8'h39);
    wrr(8'hbd, 8'h10);
    rdc("flags", 8'hbd, 8'h08);
    chk("irq", 8'h01, {7'h0, irq});
    wrr(8'hbd, 8'h08);
    rdc("flags", 8'hbd, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    $display("event test done");
  endtask
  task t_suspend;
    bus(2'h0, 10);
    rdc("flags", 8'hbd, 8'h00);
    bus(2'h0, 20);
    rdc("flags", 8'hbd, 8'h01);
    chk("irq", 8'h01, {7'h0, irq});
    @(posedge clk);
    res <= 1;
    bus(2'h1, 3);
    rdc("flags", 8'hbd, 8'h01);
    @(posedge clk);
    res <= 0;
    bus(2'h1, 2);
    rdc("flags", 8'hbd, 8'h21);
    chk("suspended", 8'h00, {7'h0, susp});
    wrr(8'hbd, 8'h01);
    rdc("flags", 8'hbd, 8'h20);
    chk("irq", 8'h01, {7'h0, irq});
    wrr(8'hbe, 8'h00);
    rdc("enable", 8'hbe, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    wrr(8'hbd, 8'h20);
    rdc("flags", 8'hbd, 8'h00);
    $display("suspend test done");
  endtask
  // frame start while the clock enable is low must leave the flags alone
  task t_freeze;
    @(posedge clk);
    ce <= 0;
    op <= 2'h3;
    repeat (2) @(posedge clk);
    ce <= 1;
    op <= 2'h1;
    rdc("frozen flags", 8'hbd, 8'h00);
    chk("frozen irq", 8'h00, {7'h0, irq});
    $display("freeze test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    t_reset;
    t_events;
    t_suspend;
    t_freeze;
    final_report;
  end
endmodule
`default_nettype wire
